// ===== shared/fsk_loop_pkg.sv
// Constants, modes and helpers for the FSK synthesizer loop control.
// Assumes an APB slave with 32-bit data and a single 10 MHz clock.

package fsk_loop_pkg;

  // Register byte offsets
  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  DIV0_OFS   = 8'h04;
  localparam logic [7:0]  DIV1_OFS   = 8'h08;
  localparam logic [7:0]  STAT_OFS   = 8'h0C;

  // Divider field widths and positions
  localparam int          A_W        = 6;
  localparam int          M_W        = 10;
  localparam int          N_W        = 12;
  localparam int          A_LSB      = 0;
  localparam int          M_LSB      = 6;
  localparam int          N_LSB      = 16;
  localparam int          DIV_W      = 28;

  // Control field positions
  localparam int          MODE_LSB   = 0;
  localparam int          OPEN_BIT   = 2;
  localparam int          PLO_BIT    = 3;
  localparam int          PHI_BIT    = 4;
  localparam int          TSEL_LSB   = 5;
  localparam logic [2:0]  TSEL_DUAL  = 3'h6;

  // Status field positions
  localparam int          ST_LOCK    = 0;
  localparam int          ST_SET1    = 1;
  localparam int          ST_LARGE   = 2;
  localparam int          ST_TRI     = 3;
  localparam int          ST_FULL    = 4;
  localparam int          ST_EMPTY   = 5;
  localparam int          ST_LOOP    = 6;

  // Reset values and sizes
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [27:0] DIV_RST    = 28'h0000000;
  localparam int          FIFO_DEPTH = 8;

  typedef enum logic [1:0] {MODE_RX, MODE_TX_SWITCH, MODE_TX_INCR, MODE_TX_VCO} fsk_mode_t;
  typedef enum logic [1:0] {LOOP_CLOSED, LOOP_ARMED, LOOP_OPEN} loop_state_t;

  function automatic logic [A_W-1:0] fieldA(input logic [DIV_W-1:0] d);
    fieldA = d[A_LSB +: A_W];
  endfunction : fieldA

  function automatic logic [M_W-1:0] fieldM(input logic [DIV_W-1:0] d);
    fieldM = d[M_LSB +: M_W];
  endfunction : fieldM

  function automatic logic [N_W-1:0] fieldN(input logic [DIV_W-1:0] d);
    fieldN = d[N_LSB +: N_W];
  endfunction : fieldN

endpackage : fsk_loop_pkg

// ===== hw/ref_tick_div.sv
// Reference-cycle divider: one-cycle tick every modulus clocks.
// Assumes modulus is stable between ticks; zero counts as one.
module ref_tick_div
  import fsk_loop_pkg::*;
(
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           resetn,
  // Divider control
  input  wire logic [M_W-1:0] modulus,
  output logic                tick
);

  typedef struct packed {
    logic [M_W-1:0] cnt;
    logic           tick;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if ((st_r.cnt + 10'h001) >= modulus)
    begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 10'h001;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tick = st_r.tick;

endmodule : ref_tick_div

// ===== hw/fsk_bit_fifo.sv
// Small FIFO with valid/ready on both sides.
// Assumes one clock; push and pop may happen together.
module fsk_bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               count;
  } fifo_state_t;

  fifo_state_t st_r;
  fifo_state_t st_nxt;
  logic        doPush;
  logic        doPop;

  assign inReady  = (st_r.count != CW'(DEPTH));
  assign outValid = (st_r.count != '0);
  assign outData  = st_r.mem[st_r.rp];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_comb
  begin
    st_nxt = st_r;
    if (doPush)
    begin
      st_nxt.mem[st_r.wp] = inData;
      st_nxt.wp           = (st_r.wp == PW'(DEPTH - 1)) ? '0 : st_r.wp + PW'(1);
    end
    if (doPop)
      st_nxt.rp = (st_r.rp == PW'(DEPTH - 1)) ? '0 : st_r.rp + PW'(1);
    if (doPush && !doPop)
      st_nxt.count = st_r.count + CW'(1);
    else if (doPop && !doPush)
      st_nxt.count = st_r.count - CW'(1);
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

endmodule : fsk_bit_fifo

// ===== hw/fsk_synth_loop_control.sv
// Synthesizer loop control for FSK transmit and receive, APB registers.
// Assumes inputs synchronous to mclk and an analog loop behind the outputs.
//
// Chosen here: the APB slave port and the address map.
module fsk_synth_loop_control
  import fsk_loop_pkg::*;
(
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           resetn,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // Loop status inputs
  input  wire logic           loopLocked,
  input  wire logic           paOn,
  // Data pin and receiver signals
  input  wire logic           dataPinIn,
  output logic                dataPinOut,
  output logic                dataPinOen,
  input  wire logic           rxDemodData,
  input  wire logic           rxSigI,
  input  wire logic           rxSigQ,
  // Divider values to the synthesizer
  output logic      [A_W-1:0] prescaleCtlDiv,
  output logic      [N_W-1:0] mainDiv,
  output logic      [M_W-1:0] refDiv,
  // Charge pump and modulation
  output logic                pumpLarge,
  output logic                pumpTristate,
  output logic                modSource,
  // Open-drain damping switch and test pins
  output logic                dampingSwitchOut,
  output logic                dampingSwitchOen,
  output logic                quadTestOut,
  output logic                quadTestOen,
  output logic                inphaseTestOut,
  // Lock indicator
  output logic                lockIndicator
);

  typedef struct packed {
    fsk_mode_t   mode;
    logic        openLoop;
    logic        pumpModeLo;
    logic        pumpModeHi;
    logic [2:0]  testSel;
    logic [DIV_W-1:0] div0;
    logic [DIV_W-1:0] div1;
    loop_state_t loop;
    logic        txBit;
    logic        useSet1;
    logic [A_W-1:0] aOut;
    logic [N_W-1:0] nOut;
    logic [M_W-1:0] mOut;
    logic        pumpLarge;
    logic        pumpTri;
    logic        modSrc;
    logic        dampOen;
    logic        quadOut;
    logic        quadOen;
    logic        iOut;
    logic        lockInd;
    logic        dataOut;
    logic        dataOen;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ctl_state_t;

  ctl_state_t st_r;
  ctl_state_t st_nxt;

  logic refTick;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic fifoHead;
  logic txMode;
  logic fifoPush;
  logic fifoPop;
  logic fastLock;
  logic dualFilter;
  logic addrOk;

  // Reference-cycle boundaries follow the active reference divider
  ref_tick_div u_ref_div (
    .mclk    (mclk),
    .resetn  (resetn),
    .modulus (st_r.mOut),
    .tick    (refTick)
  );

  assign txMode   = (st_r.mode != MODE_RX);
  // Pin sampled once per reference cycle while transmitting
  assign fifoPush = txMode && refTick;
  // Drain stalls while an open loop still waits for lock and paOn
  assign fifoOutReady = refTick && !(st_r.openLoop && st_r.loop == LOOP_CLOSED);
  assign fifoPop  = fifoOutValid && fifoOutReady;

  fsk_bit_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .resetn   (resetn),
    .inValid  (fifoPush),
    .inReady  (fifoInReady),
    .inData   (dataPinIn),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoHead)
  );

  assign fastLock   = st_r.pumpModeHi && (txMode || !st_r.pumpModeLo);
  assign dualFilter = (st_r.testSel == TSEL_DUAL);
  assign addrOk     = (paddr == CTRL_OFS) || (paddr == DIV0_OFS) ||
                      (paddr == DIV1_OFS) || (paddr == STAT_OFS);

  always_comb
  begin
    st_nxt = st_r;

    // APB: setup cycle prepares the answer, access completes at once
    st_nxt.pready  = psel && !penable;
    st_nxt.pslverr = psel && !penable && !addrOk;
    if (psel && !penable)
    begin
      case (paddr)
        CTRL_OFS: st_nxt.prdata = {24'h000000, st_r.testSel, st_r.pumpModeHi, st_r.pumpModeLo,
                                   st_r.openLoop, st_r.mode};
        DIV0_OFS: st_nxt.prdata = {4'h0, st_r.div0};
        DIV1_OFS: st_nxt.prdata = {4'h0, st_r.div1};
        STAT_OFS: st_nxt.prdata = {25'h0000000, st_r.loop != LOOP_CLOSED, !fifoOutValid,
                                   !fifoInReady, st_r.pumpTri, st_r.pumpLarge, st_r.useSet1,
                                   st_r.lockInd};
        default:  st_nxt.prdata = 32'h00000000;
      endcase
    end
    if (psel && penable && st_r.pready && pwrite)
    begin
      case (paddr)
        CTRL_OFS:
        begin
          st_nxt.mode       = fsk_mode_t'(pwdata[MODE_LSB +: 2]);
          st_nxt.openLoop   = pwdata[OPEN_BIT];
          st_nxt.pumpModeLo = pwdata[PLO_BIT];
          st_nxt.pumpModeHi = pwdata[PHI_BIT];
          st_nxt.testSel    = pwdata[TSEL_LSB +: 3];
        end
        DIV0_OFS: st_nxt.div0 = pwdata[DIV_W-1:0];
        DIV1_OFS: st_nxt.div1 = pwdata[DIV_W-1:0];
        default:  st_nxt.div0 = st_r.div0;
      endcase
    end

    // Data taken from the FIFO at a reference-cycle boundary
    if (fifoPop)
      st_nxt.txBit = fifoHead;

    // Divider set selection only on reference ticks
    if (refTick)
    begin
      case (st_r.mode)
        MODE_RX:        st_nxt.useSet1 = 1'b0;
        MODE_TX_SWITCH: st_nxt.useSet1 = fifoPop ? fifoHead : st_r.txBit;
        MODE_TX_INCR:   st_nxt.useSet1 = 1'b1;
        MODE_TX_VCO:    st_nxt.useSet1 = 1'b1;
        default:        st_nxt.useSet1 = 1'b0;
      endcase
      st_nxt.aOut = st_nxt.useSet1 ? fieldA(st_r.div1) : fieldA(st_r.div0);
      st_nxt.nOut = st_nxt.useSet1 ? fieldN(st_r.div1) : fieldN(st_r.div0);
      st_nxt.mOut = st_nxt.useSet1 ? fieldM(st_r.div1) : fieldM(st_r.div0);
      if (st_r.mode == MODE_TX_INCR)
        st_nxt.aOut = st_nxt.txBit ? fieldA(st_r.div1) + 6'h01 : fieldA(st_r.div1) - 6'h01;
    end

    // Modulation current follows the transmit bit
    st_nxt.modSrc = st_nxt.txBit;

    // Charge pump current and damping switch
    if (st_r.pumpModeHi)
      st_nxt.pumpLarge = fastLock ? !loopLocked : 1'b1;
    else
      st_nxt.pumpLarge = st_r.pumpModeLo;
    st_nxt.dampOen = !(fastLock && !loopLocked);

    // Open-loop sequencing
    case (st_r.loop)
      LOOP_CLOSED:
        if (txMode && st_r.openLoop && loopLocked && paOn)
          st_nxt.loop = LOOP_ARMED;
      LOOP_ARMED:
        if (fifoPop)
          st_nxt.loop = LOOP_OPEN;
      LOOP_OPEN:
        st_nxt.loop = LOOP_OPEN;
      default:
        st_nxt.loop = LOOP_CLOSED;
    endcase
    if (!txMode || !st_r.openLoop)
      st_nxt.loop = LOOP_CLOSED;
    st_nxt.pumpTri = (st_nxt.loop == LOOP_OPEN);

    // Test pins and dual-filter switch
    if (dualFilter)
    begin
      st_nxt.quadOut = 1'b0;
      st_nxt.quadOen = !txMode;
      st_nxt.iOut    = 1'b0;
    end
    else
    begin
      st_nxt.quadOut = rxSigQ;
      st_nxt.quadOen = 1'b0;
      st_nxt.iOut    = rxSigI;
    end

    // Lock indicator
    st_nxt.lockInd = loopLocked;

    // Data pin: released in transmit, drives receive data otherwise
    st_nxt.dataOen = txMode;
    st_nxt.dataOut = txMode ? 1'b0 : rxDemodData;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      st_r          <= '0;
      st_r.mode     <= MODE_RX;
      st_r.loop     <= LOOP_CLOSED;
      st_r.div0     <= DIV_RST;
      st_r.div1     <= DIV_RST;
      st_r.dampOen  <= 1'b1;
      st_r.quadOen  <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata           = st_r.prdata;
  assign pready           = st_r.pready;
  assign pslverr          = st_r.pslverr;
  assign dataPinOut       = st_r.dataOut;
  assign dataPinOen       = st_r.dataOen;
  assign prescaleCtlDiv   = st_r.aOut;
  assign mainDiv          = st_r.nOut;
  assign refDiv           = st_r.mOut;
  assign pumpLarge        = st_r.pumpLarge;
  assign pumpTristate     = st_r.pumpTri;
  assign modSource        = st_r.modSrc;
  assign dampingSwitchOut = 1'b0;
  assign dampingSwitchOen = st_r.dampOen;
  assign quadTestOut      = st_r.quadOut;
  assign quadTestOen      = st_r.quadOen;
  assign inphaseTestOut   = st_r.iOut;
  assign lockIndicator    = st_r.lockInd;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Divider selection
  a_rx_set0: assert property (refTick && st_r.mode == MODE_RX |=>
    mainDiv == fieldN($past(st_r.div0)) && refDiv == fieldM($past(st_r.div0)))
    else $error("receive did not load divider set 0");
  a_switch_set: assert property (refTick && fifoPop && st_r.mode == MODE_TX_SWITCH |=>
    mainDiv == ($past(fifoHead) ? fieldN($past(st_r.div1)) : fieldN($past(st_r.div0))))
    else $error("divider switch does not follow data");
  a_incr_step: assert property (refTick && fifoPop && st_r.mode == MODE_TX_INCR |=>
    prescaleCtlDiv == ($past(fifoHead) ? fieldA($past(st_r.div1)) + 6'h01 : fieldA($past(st_r.div1)) - 6'h01))
    else $error("prescaler step wrong");
  a_vco_set1: assert property (refTick && st_r.mode == MODE_TX_VCO |=>
    mainDiv == fieldN($past(st_r.div1)))
    else $error("oscillator mode not on set 1");
  a_set_tick: assert property (!refTick |=>
    $stable(mainDiv) && $stable(refDiv) && $stable(prescaleCtlDiv))
    else $error("divider changed between reference ticks");

  // Modulation and charge pump
  a_mod_data: assert property (fifoPop |=> modSource == $past(fifoHead))
    else $error("modulation current does not follow data");
  a_mod_hold: assert property (!fifoPop |=> $stable(modSource))
    else $error("modulation current changed without new data");
  a_fast_unlock: assert property (st_r.pumpModeHi && !st_r.pumpModeLo && txMode && !loopLocked |=>
    pumpLarge && !dampingSwitchOen)
    else $error("fast lock not engaged while unlocked");
  a_fast_relock: assert property (fastLock && loopLocked |=> !pumpLarge && dampingSwitchOen)
    else $error("fast lock not released on lock");
  a_rx_large: assert property (st_r.pumpModeHi && st_r.pumpModeLo && !txMode |=> pumpLarge)
    else $error("receive not on large current");
  a_fixed_pump: assert property (!st_r.pumpModeHi |=> pumpLarge == $past(st_r.pumpModeLo))
    else $error("fixed pump current wrong");

  // Test pins, lock indicator and data pin
  a_dual_quiet: assert property (dualFilter |=> !inphaseTestOut && !quadTestOut)
    else $error("test pins show receiver signals");
  a_dual_ground: assert property (dualFilter && txMode |=> !quadTestOen && !quadTestOut)
    else $error("transmit filter not grounded");
  a_dual_rx: assert property (dualFilter && !txMode |=> quadTestOen)
    else $error("filter switch active in receive");
  a_test_show: assert property (!dualFilter |=>
    inphaseTestOut == $past(rxSigI) && quadTestOut == $past(rxSigQ))
    else $error("test pins do not show receiver signals");
  a_lock_follow: assert property (loopLocked |=> lockIndicator)
    else $error("lock indicator low while locked");
  a_lock_drop: assert property (!loopLocked |=> !lockIndicator)
    else $error("lock indicator high while unlocked");
  a_data_release: assert property (txMode |=> dataPinOen)
    else $error("data pin driven in transmit");
  a_pin_rx: assert property (!txMode |=> !dataPinOen && dataPinOut == $past(rxDemodData))
    else $error("receive data not driven on pin");

  // Open loop
  a_open_cause: assert property ($rose(pumpTristate) |-> $past(st_r.loop) == LOOP_ARMED &&
    st_r.openLoop && txMode)
    else $error("pump opened without armed loop");
  a_open_step: assert property (st_r.loop == LOOP_ARMED && fifoPop && txMode && st_r.openLoop |=>
    pumpTristate)
    else $error("loop did not open with first data");
  a_hold_closed: assert property (st_r.openLoop && txMode && st_r.loop == LOOP_CLOSED |=>
    !pumpTristate && $stable(modSource))
    else $error("modulation started before loop lock");
  a_pump_closed: assert property (!(txMode && st_r.openLoop) |=> !pumpTristate)
    else $error("pump open outside open-loop transmit");

  // Register bus
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_apb_err: assert property (psel && !penable && !addrOk |=>
    pslverr && prdata == 32'h00000000)
    else $error("unmapped address not refused");

  c_switch_tx: cover property (st_r.mode == MODE_TX_SWITCH && fifoPop ##1 st_r.useSet1);
  c_open_loop: cover property ($rose(pumpTristate));
  c_fifo_full: cover property (!fifoInReady);
  c_fast_lock: cover property (!dampingSwitchOen ##[1:50] dampingSwitchOen);
  c_incr_tx: cover property (st_r.mode == MODE_TX_INCR && fifoPop);

endmodule : fsk_synth_loop_control

// ===== sim/fsk_baseband_model.sv
// Baseband controller model: sends transmit bits on the shared data pin.
// Assumes the bench says when to send; resolves the pin from both drivers.
module fsk_baseband_model
(
  // Clock
  input  wire logic mclk,
  // Bench commands
  input  wire logic sendEn,
  input  wire logic txBit,
  // Device side of the pin
  input  wire logic dataPinOut,
  input  wire logic dataPinOen,
  output logic      dataPinIn
);
  timeunit 1ns;
  timeprecision 1ns;

  logic lastLevel_r = 1'b0;

  // Pin left floating whenever neither the device nor the sender drives it
  always_comb
  begin
    if (dataPinOen == 1'b0)
      dataPinIn = dataPinOut;
    else if (sendEn)
      dataPinIn = txBit;
    else
      dataPinIn = ~lastLevel_r;
  end

  // Floating pin shows a changing level
  always_ff @(posedge mclk)
    lastLevel_r <= dataPinIn;
endmodule : fsk_baseband_model

// ===== sim/fsk_synth_loop_control_test.sv
// Self-checking bench for the FSK synthesizer loop control.
// Assumes package, design sources and baseband model compiled first.
module fsk_synth_loop_control_test
  import fsk_loop_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [31:0] D0  = {4'h0, 12'h155, 10'h003, 6'h2A};
  localparam logic [31:0] D1  = {4'h0, 12'h2AB, 10'h003, 6'h3F};
  localparam logic [29:0] MDM = 30'h1FFFFFFF;
  localparam logic [29:0] TRM = 30'h20000000;

  logic        mclk = 1'b0;
  logic        resetn, psel, penable, pwrite, loopLocked, paOn;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, dataPinOut, dataPinOen, rxDemodData;
  logic        rxSigI, rxSigQ, pumpLarge, pumpTristate, modSource;
  logic        dampingSwitchOut, dampingSwitchOen, quadTestOut, quadTestOen;
  logic        inphaseTestOut, lockIndicator, sendEn, txBit;
  wire logic   dataPinIn;
  logic [5:0]  prescaleCtlDiv;
  logic [11:0] mainDiv;
  logic [9:0]  refDiv;
  wire logic [29:0] obs = {pumpTristate, modSource, mainDiv, refDiv, prescaleCtlDiv};
  int          errTotal = 0;
  int          numChecks = 0;

  always #50 mclk = ~mclk;

  fsk_synth_loop_control DUT
  (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .loopLocked(loopLocked), .paOn(paOn), .dataPinIn(dataPinIn), .dataPinOut(dataPinOut),
    .dataPinOen(dataPinOen), .rxDemodData(rxDemodData), .rxSigI(rxSigI), .rxSigQ(rxSigQ),
    .prescaleCtlDiv(prescaleCtlDiv), .mainDiv(mainDiv), .refDiv(refDiv),
    .pumpLarge(pumpLarge), .pumpTristate(pumpTristate), .modSource(modSource),
    .dampingSwitchOut(dampingSwitchOut), .dampingSwitchOen(dampingSwitchOen),
    .quadTestOut(quadTestOut), .quadTestOen(quadTestOen),
    .inphaseTestOut(inphaseTestOut), .lockIndicator(lockIndicator)
  );

  fsk_baseband_model bbModel
  (
    .mclk(mclk), .sendEn(sendEn), .txBit(txBit),
    .dataPinOut(dataPinOut), .dataPinOen(dataPinOen), .dataPinIn(dataPinIn)
  );

  task automatic finalReport();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finalReport

  task automatic chkBit(input string nm, input logic e, input logic g);
    numChecks++;
    if (g !== e)
    begin
      errTotal++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chkBit

  task automatic chkWord(input string nm, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e)
    begin
      errTotal++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chkWord

  // One APB transfer, checking the response
  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      errTotal++;
      finalReport();
    end
    chkBit("pslverr", ee, pslverr);
    if (!w)
      chkWord("prdata", ed, prdata);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : acc

  task automatic drv(input logic s, input logic b);
    @(posedge mclk);
    sendEn <= s;
    txBit  <= b;
  endtask : drv

  // Bounded wait for masked outputs
  task automatic waitObs(input logic [29:0] e, input logic [29:0] mk);
    int k;
    k = 0;
    while ((obs & mk) !== (e & mk) && k < 200)
    begin
      @(negedge mclk);
      k++;
    end
    chkWord("outputs", {2'b00, e & mk}, {2'b00, obs & mk});
    if (k >= 200)
      finalReport();
  endtask : waitObs

  function automatic logic [31:0] ctl(input fsk_mode_t md, input logic op, input logic [1:0] pm,
                                      input logic [2:0] ts);
    ctl = 32'h0;
    ctl[MODE_LSB +: 2] = md;
    ctl[OPEN_BIT] = op;
    ctl[PHI_BIT] = pm[1];
    ctl[PLO_BIT] = pm[0];
    ctl[TSEL_LSB +: 3] = ts;
  endfunction : ctl

  initial
  begin
    int   m;
    logic lk;
    logic tx;
    logic ex;
    resetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    loopLocked <= 1'b0;
    paOn <= 1'b0;
    rxDemodData <= 1'b0;
    rxSigI <= 1'b0;
    rxSigQ <= 1'b0;
    sendEn <= 1'b0;
    txBit <= 1'b0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    chkBit("pinOen", 1'b0, dataPinOen);
    chkBit("dampOen", 1'b1, dampingSwitchOen);
    acc(CTRL_OFS, 1'b0, 32'h0, 32'h0, 1'b0);
    acc(STAT_OFS, 1'b0, 32'h0, 32'h20, 1'b0);
    acc(DIV0_OFS, 1'b1, D0, 32'h0, 1'b0);
    acc(DIV1_OFS, 1'b1, D1, 32'h0, 1'b0);
    acc(DIV0_OFS, 1'b0, 32'h0, D0, 1'b0);
    acc(DIV1_OFS, 1'b0, 32'h0, D1, 1'b0);
    acc(STAT_OFS, 1'b1, 32'hFF, 32'h0, 1'b0);
    acc(STAT_OFS, 1'b0, 32'h0, 32'h20, 1'b0);
    acc(8'h10, 1'b1, 32'h5, 32'h0, 1'b1);
    acc(8'h10, 1'b0, 32'h0, 32'h0, 1'b1);
    waitObs({2'b00, D0[27:0]}, 30'h0FFFFFFF);
    @(posedge mclk);
    loopLocked <= 1'b1;
    rxDemodData <= 1'b1;
    repeat (2) @(negedge mclk);
    chkBit("lockInd", 1'b1, lockIndicator);
    chkBit("pinOut", 1'b1, dataPinOut);
    @(posedge mclk);
    loopLocked <= 1'b0;
    repeat (2) @(negedge mclk);
    chkBit("lockInd", 1'b0, lockIndicator);
    acc(CTRL_OFS, 1'b1, ctl(MODE_TX_SWITCH, 1'b0, 2'b00, 3'h0), 32'h0, 1'b0);
    drv(1'b1, 1'b1);
    waitObs({2'b01, D1[27:0]}, MDM);
    chkBit("pinOen", 1'b1, dataPinOen);
    drv(1'b1, 1'b0);
    waitObs({2'b00, D0[27:0]}, MDM);
    acc(CTRL_OFS, 1'b1, ctl(MODE_TX_INCR, 1'b0, 2'b00, 3'h0), 32'h0, 1'b0);
    drv(1'b1, 1'b1);
    waitObs({2'b01, D1[27:6], 6'h00}, MDM);
    drv(1'b1, 1'b0);
    waitObs({2'b00, D1[27:6], 6'h3E}, MDM);
    acc(CTRL_OFS, 1'b1, ctl(MODE_TX_VCO, 1'b0, 2'b00, 3'h0), 32'h0, 1'b0);
    waitObs({2'b00, D1[27:0]}, MDM);
    drv(1'b1, 1'b1);
    waitObs({2'b01, D1[27:0]}, MDM);
    drv(1'b0, 1'b0);
    for (m = 0; m < 16; m++)
    begin
      tx = m[3];
      lk = m[2];
      acc(CTRL_OFS, 1'b1, ctl(tx ? MODE_TX_VCO : MODE_RX, 1'b0, m[1:0], 3'h0), 32'h0, 1'b0);
      loopLocked <= lk;
      repeat (3) @(negedge mclk);
      ex = (m[1:0] == 2'b01) || (m[1] && !lk) || (m[1:0] == 2'b11 && !tx);
      chkBit("pumpLarge", ex, pumpLarge);
      chkBit("dampOut", 1'b0, dampingSwitchOut);
      if (!(m[1:0] == 2'b11 && !tx))
        chkBit("dampOen", !(m[1] && !lk), dampingSwitchOen);
    end
    @(posedge mclk);
    rxSigI <= 1'b1;
    rxSigQ <= 1'b1;
    repeat (3) @(negedge mclk);
    chkBit("inphase", 1'b1, inphaseTestOut);
    chkBit("quadOut", 1'b1, quadTestOut);
    drv(1'b1, 1'b0);
    acc(CTRL_OFS, 1'b1, ctl(MODE_TX_VCO, 1'b0, 2'b00, TSEL_DUAL), 32'h0, 1'b0);
    rxSigI <= 1'b1;
    rxSigQ <= 1'b1;
    repeat (3) @(negedge mclk);
    chkBit("quadOen", 1'b0, quadTestOen);
    chkBit("quadOut", 1'b0, quadTestOut);
    chkBit("inphase", 1'b0, inphaseTestOut);
    @(posedge mclk);
    rxSigI <= 1'b0;
    rxSigQ <= 1'b0;
    repeat (3) @(negedge mclk);
    chkBit("inphase", 1'b0, inphaseTestOut);
    acc(CTRL_OFS, 1'b1, ctl(MODE_RX, 1'b0, 2'b00, TSEL_DUAL), 32'h0, 1'b0);
    repeat (3) @(negedge mclk);
    chkBit("quadOen", 1'b1, quadTestOen);
    acc(CTRL_OFS, 1'b1, ctl(MODE_TX_VCO, 1'b1, 2'b00, 3'h0), 32'h0, 1'b0);
    loopLocked <= 1'b0;
    drv(1'b1, 1'b1);
    // Eight ticks of three cycles fill the buffer
    repeat (40) @(negedge mclk);
    chkBit("pumpTri", 1'b0, pumpTristate);
    acc(STAT_OFS, 1'b0, 32'h0, 32'h12, 1'b0);
    @(posedge mclk);
    loopLocked <= 1'b1;
    paOn <= 1'b1;
    waitObs(TRM, TRM);
    for (m = 0; m < 4; m++)
    begin
      drv(1'b1, m[0]);
      repeat (6) @(negedge mclk);
      chkBit("pumpTri", 1'b1, pumpTristate);
    end
    acc(CTRL_OFS, 1'b1, ctl(MODE_TX_VCO, 1'b0, 2'b00, 3'h0), 32'h0, 1'b0);
    waitObs(30'h0, TRM);
    finalReport();
  end
endmodule : fsk_synth_loop_control_test
